// ===== core/pxb_pkg.sv
// Constants shared by the port crossbar and pin configuration block
package pxb_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NPORT    = 5;
	localparam int NPIN     = 40;
	localparam int NXPIN    = 32;
	localparam int NSIG     = 23;
	localparam int SIG_W    = 5;
	localparam int ADDR_W   = 8;

	// ----------------------------------------
	// Register map: region in addr[7:3], port in addr[2:0]
	// ----------------------------------------
	localparam logic [4:0] REG_LATCH  = 5'h00;
	localparam logic [4:0] REG_INMODE = 5'h01;
	localparam logic [4:0] REG_OUTMODE = 5'h02;
	localparam logic [4:0] REG_SKIP   = 5'h03;
	localparam logic [4:0] REG_XBAR   = 5'h04;
	localparam logic [2:0] XBAR_LOW   = 3'h0;
	localparam logic [2:0] XBAR_HIGH  = 3'h1;
	localparam logic [2:0] XBAR_EXTRA = 3'h2;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int LOW_UART   = 0;
	localparam int LOW_SPI    = 1;
	localparam int LOW_SMB0   = 2;
	localparam int LOW_SYSCLK = 3;
	localparam int LOW_CMP0   = 4;
	localparam int LOW_CMP0A  = 5;
	localparam int LOW_CMP1   = 6;
	localparam int LOW_CMP1A  = 7;
	localparam int HIGH_PCA_LSB = 0;
	localparam int HIGH_ECI   = 3;
	localparam int HIGH_TMR0  = 4;
	localparam int HIGH_TMR1  = 5;
	localparam int HIGH_CROSSBAR_ENABLE = 6;
	localparam int HIGH_WPUD  = 7;
	localparam int EXTRA_SMB1 = 0;
	localparam int EXTRA_SPI4 = 1;
	localparam logic [2:0] PCA_MAX = 3'h5;

	// ----------------------------------------
	// Peripheral signal indices, in priority order
	// ----------------------------------------
	localparam logic [SIG_W-1:0] SIG_UTX   = 5'h00;
	localparam logic [SIG_W-1:0] SIG_URX   = 5'h01;
	localparam logic [SIG_W-1:0] SIG_SCK   = 5'h02;
	localparam logic [SIG_W-1:0] SIG_MISO  = 5'h03;
	localparam logic [SIG_W-1:0] SIG_MOSI  = 5'h04;
	localparam logic [SIG_W-1:0] SIG_SSEL  = 5'h05;
	localparam logic [SIG_W-1:0] SIG_SDA0  = 5'h06;
	localparam logic [SIG_W-1:0] SIG_SCL0  = 5'h07;
	localparam logic [SIG_W-1:0] SIG_SECOND_SMBUS_DATA  = 5'h08;
	localparam logic [SIG_W-1:0] SIG_SECOND_SMBUS_CLOCK  = 5'h09;
	localparam logic [SIG_W-1:0] SIG_SYSCK = 5'h0a;
	localparam logic [SIG_W-1:0] SIG_CP0   = 5'h0b;
	localparam logic [SIG_W-1:0] SIG_CP0A  = 5'h0c;
	localparam logic [SIG_W-1:0] SIG_CP1   = 5'h0d;
	localparam logic [SIG_W-1:0] SIG_CP1A  = 5'h0e;
	localparam logic [SIG_W-1:0] SIG_CEX0  = 5'h0f;
	localparam logic [SIG_W-1:0] SIG_ECI   = 5'h14;
	localparam logic [SIG_W-1:0] SIG_TMR0  = 5'h15;
	localparam logic [SIG_W-1:0] SIG_TMR1  = 5'h16;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [NPIN-1:0]  RST_LATCH   = 40'hff_ffff_ffff;
	localparam logic [NPIN-1:0]  RST_INMODE  = 40'hff_ffff_ffff;
	localparam logic [NPIN-1:0]  RST_OUTMODE = 40'h00_0000_0000;
	localparam logic [NXPIN-1:0] RST_SKIP    = 32'h0000_0000;
	localparam logic [7:0]       RST_XBAR    = 8'h00;

endpackage : pxb_pkg

// ===== core/pxb_sync.sv
// Two-flop synchroniser for the pad inputs
`timescale 1ns/10ps
module pxb_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	import pxb_pkg::*;

	logic [W-1:0] meta;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : pxb_sync

// ===== core/pxb_priority_decode.sv
// Crossbar priority decoder: enabled signals onto non-skipped pins
`timescale 1ns/10ps
module pxb_priority_decode (
	input  wire logic [pxb_pkg::NSIG-1:0]             sigEnable,
	input  wire logic [pxb_pkg::NXPIN-1:0]            skipMask,
	output logic      [pxb_pkg::NXPIN-1:0]            pinAssigned,
	output logic      [pxb_pkg::NXPIN*pxb_pkg::SIG_W-1:0] pinSignal
);
	import pxb_pkg::*;

	// Each free pin takes the next enabled signal in priority order
	always_comb begin
		int  cursor;
		logic found;
		cursor      = 0;
		found       = 1'b0;
		pinAssigned = '0;
		pinSignal   = '0;
		for (int p = 0; p < NXPIN; p++) begin
			found = 1'b0;
			if (!skipMask[p]) begin
				for (int s = 0; s < NSIG; s++) begin
					if (!found && s >= cursor && sigEnable[s]) begin
						found                      = 1'b1;
						pinAssigned[p]             = 1'b1;
						pinSignal[p*SIG_W +: SIG_W] = SIG_W'(s);
						cursor                     = s + 1;
					end
				end
			end
		end
	end

endmodule : pxb_priority_decode

// ===== core/pxb_port_crossbar.sv
// Port pin configuration registers, crossbar gating and pad control
`timescale 1ns/10ps
module pxb_port_crossbar (
	input  wire logic                        mclk,
	input  wire logic                        rstn,
	input  wire logic [pxb_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [7:0]                  regWrData,
	input  wire logic                        regWr,
	input  wire logic                        regRd,
	output logic      [7:0]                  regRdData,
	input  wire logic [pxb_pkg::NPIN-1:0]    pinIn,
	output logic      [pxb_pkg::NPIN-1:0]    pinOut,
	output logic      [pxb_pkg::NPIN-1:0]    pinOe,
	output logic      [pxb_pkg::NPIN-1:0]    pinPullup,
	output logic      [pxb_pkg::NPIN-1:0]    pinRxEnable,
	input  wire logic [pxb_pkg::NSIG-1:0]    perOut,
	input  wire logic [pxb_pkg::NSIG-1:0]    perOe,
	output logic      [pxb_pkg::NSIG-1:0]    perIn
);
	import pxb_pkg::*;

	// ----------------------------------------
	// Configuration state
	// ----------------------------------------
	logic [NPIN-1:0]        portLatch;
	logic [NPIN-1:0]        portInputMode;
	logic [NPIN-1:0]        portOutputMode;
	logic [NXPIN-1:0]       portSkipMask;
	logic [7:0]             crossbarAssignLow;
	logic [7:0]             crossbarAssignHigh;
	logic [7:0]             crossbarAssignExtra;

	logic                   crossbarEnable;
	logic                   weakPullupDisable;
	logic [NPIN-1:0]        pinSync;
	logic [NSIG-1:0]        sigEnable;
	logic [NXPIN-1:0]       pinAssigned;
	logic [NXPIN*SIG_W-1:0] pinSignal;
	logic [NPIN-1:0]        next_pinOut;
	logic [NPIN-1:0]        next_pinOe;
	logic [NPIN-1:0]        next_pinPullup;
	logic [NPIN-1:0]        next_pinRxEnable;
	logic [NSIG-1:0]        next_perIn;
	logic [7:0]             next_regRdData;

	assign crossbarEnable    = crossbarAssignHigh[HIGH_CROSSBAR_ENABLE];
	assign weakPullupDisable = crossbarAssignHigh[HIGH_WPUD];

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Per-port regions exist for ports 0-4; skip masks only for ports 0-3
	function automatic logic portHit(input logic [ADDR_W-1:0] a, input logic [4:0] region);
		logic [2:0] idx;
		idx = a[2:0];
		if (a[ADDR_W-1:3] != region)
			return 1'b0;
		if (region == REG_SKIP)
			return idx < 3'(NXPIN / 8);
		return idx < 3'(NPORT);
	endfunction : portHit

	function automatic logic xbarHit(input logic [ADDR_W-1:0] a, input logic [2:0] which);
		return a[ADDR_W-1:3] == REG_XBAR && a[2:0] == which;
	endfunction : xbarHit

	// SMBus data and clock lines of both instances
	function automatic logic isSmbus(input logic [SIG_W-1:0] s);
		return s == SIG_SDA0 || s == SIG_SCL0 || s == SIG_SECOND_SMBUS_DATA || s == SIG_SECOND_SMBUS_CLOCK;
	endfunction : isSmbus

	// ----------------------------------------
	// Pad input synchroniser
	// ----------------------------------------
	pxb_sync #(
		.W (NPIN)
	) uPinSync (
		.mclk (mclk),
		.rstn (rstn),
		.d    (pinIn),
		.q    (pinSync)
	);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			portLatch <= RST_LATCH;
		end else if (regWr && portHit(regAddr, REG_LATCH)) begin
			portLatch[regAddr[2:0]*8 +: 8] <= regWrData;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			portInputMode <= RST_INMODE;
		end else if (regWr && portHit(regAddr, REG_INMODE)) begin
			portInputMode[regAddr[2:0]*8 +: 8] <= regWrData;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			portOutputMode <= RST_OUTMODE;
		end else if (regWr && portHit(regAddr, REG_OUTMODE)) begin
			portOutputMode[regAddr[2:0]*8 +: 8] <= regWrData;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			portSkipMask <= RST_SKIP;
		end else if (regWr && portHit(regAddr, REG_SKIP)) begin
			portSkipMask[regAddr[2:0]*8 +: 8] <= regWrData;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			crossbarAssignLow   <= RST_XBAR;
			crossbarAssignHigh  <= RST_XBAR;
			crossbarAssignExtra <= RST_XBAR;
		end else if (regWr) begin
			if (xbarHit(regAddr, XBAR_LOW))
				crossbarAssignLow <= regWrData;
			if (xbarHit(regAddr, XBAR_HIGH))
				crossbarAssignHigh <= regWrData;
			if (xbarHit(regAddr, XBAR_EXTRA))
				crossbarAssignExtra <= {6'h00, regWrData[1:0]};
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	// The latch address reads the pad level, as the port receiver sees it
	always_comb begin
		next_regRdData = 8'h00;
		if (portHit(regAddr, REG_LATCH))
			next_regRdData = pinSync[regAddr[2:0]*8 +: 8] & portInputMode[regAddr[2:0]*8 +: 8];
		else if (portHit(regAddr, REG_INMODE))
			next_regRdData = portInputMode[regAddr[2:0]*8 +: 8];
		else if (portHit(regAddr, REG_OUTMODE))
			next_regRdData = portOutputMode[regAddr[2:0]*8 +: 8];
		else if (portHit(regAddr, REG_SKIP))
			next_regRdData = portSkipMask[regAddr[2:0]*8 +: 8];
		else if (xbarHit(regAddr, XBAR_LOW))
			next_regRdData = crossbarAssignLow;
		else if (xbarHit(regAddr, XBAR_HIGH))
			next_regRdData = crossbarAssignHigh;
		else if (xbarHit(regAddr, XBAR_EXTRA))
			next_regRdData = crossbarAssignExtra;
	end

	// Read data stands for exactly the cycle after the strobe
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			regRdData <= 8'h00;
		end else if (regRd) begin
			regRdData <= next_regRdData;
		end else begin
			regRdData <= 8'h00;
		end
	end

	// ----------------------------------------
	// Peripheral signal requests
	// ----------------------------------------
	always_comb begin
		logic [2:0] pcaCount;
		pcaCount  = crossbarAssignHigh[HIGH_PCA_LSB +: 3];
		sigEnable = '0;
		sigEnable[SIG_UTX]   = crossbarAssignLow[LOW_UART];
		sigEnable[SIG_URX]   = crossbarAssignLow[LOW_UART];
		sigEnable[SIG_SCK]   = crossbarAssignLow[LOW_SPI];
		sigEnable[SIG_MISO]  = crossbarAssignLow[LOW_SPI];
		sigEnable[SIG_MOSI]  = crossbarAssignLow[LOW_SPI];
		sigEnable[SIG_SSEL]  = crossbarAssignLow[LOW_SPI]
			&& crossbarAssignExtra[EXTRA_SPI4];
		sigEnable[SIG_SDA0]  = crossbarAssignLow[LOW_SMB0];
		sigEnable[SIG_SCL0]  = crossbarAssignLow[LOW_SMB0];
		sigEnable[SIG_SECOND_SMBUS_DATA]  = crossbarAssignExtra[EXTRA_SMB1];
		sigEnable[SIG_SECOND_SMBUS_CLOCK]  = crossbarAssignExtra[EXTRA_SMB1];
		sigEnable[SIG_SYSCK] = crossbarAssignLow[LOW_SYSCLK];
		sigEnable[SIG_CP0]   = crossbarAssignLow[LOW_CMP0];
		sigEnable[SIG_CP0A]  = crossbarAssignLow[LOW_CMP0A];
		sigEnable[SIG_CP1]   = crossbarAssignLow[LOW_CMP1];
		sigEnable[SIG_CP1A]  = crossbarAssignLow[LOW_CMP1A];
		// Reserved module counts route no capture/compare outputs
		for (int k = 0; k < 5; k++)
			sigEnable[SIG_CEX0 + k] = pcaCount <= PCA_MAX && pcaCount > 3'(k);
		sigEnable[SIG_ECI]   = crossbarAssignHigh[HIGH_ECI];
		sigEnable[SIG_TMR0]  = crossbarAssignHigh[HIGH_TMR0];
		sigEnable[SIG_TMR1]  = crossbarAssignHigh[HIGH_TMR1];
	end

	pxb_priority_decode uDecode (
		.sigEnable   (sigEnable),
		.skipMask    (portSkipMask),
		.pinAssigned (pinAssigned),
		.pinSignal   (pinSignal)
	);

	// ----------------------------------------
	// Pad control
	// ----------------------------------------
	always_comb begin
		logic              digital;
		logic              xbarPin;
		logic              routed;
		logic              openDrain;
		logic              value;
		logic [SIG_W-1:0]  sel;
		digital          = 1'b0;
		xbarPin          = 1'b0;
		routed           = 1'b0;
		openDrain        = 1'b0;
		value            = 1'b0;
		sel              = '0;
		next_pinOut      = '0;
		next_pinOe       = '0;
		next_pinPullup   = '0;
		next_pinRxEnable = '0;
		for (int p = 0; p < NPIN; p++) begin
			digital = portInputMode[p];
			xbarPin = p < NXPIN;
			routed  = 1'b0;
			sel     = '0;
			if (xbarPin) begin
				routed = crossbarEnable && pinAssigned[p];
				sel    = pinSignal[p*SIG_W +: SIG_W];
			end
			// A peripheral that is not driving puts a high on its pin: released if open-drain, driven if push-pull
			value     = routed ? (perOe[sel] ? perOut[sel] : 1'b1) : portLatch[p];
			openDrain = !portOutputMode[p] || (routed && isSmbus(sel));
			if (digital && (!xbarPin || crossbarEnable)) begin
				next_pinOe[p] = openDrain ? !value : 1'b1;
			end
			next_pinOut[p]      = openDrain ? 1'b0 : value;
			next_pinPullup[p]   = digital && openDrain && !weakPullupDisable
				&& !(next_pinOe[p] && !next_pinOut[p]);
			next_pinRxEnable[p] = digital;
		end
	end

	// Receive side: each routed input signal sees its pad, or a high if its pin is analog; idle inputs read high
	always_comb begin
		next_perIn = '1;
		for (int p = 0; p < NXPIN; p++) begin
			if (crossbarEnable && pinAssigned[p])
				next_perIn[pinSignal[p*SIG_W +: SIG_W]] = pinSync[p] || !portInputMode[p];
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pinOut      <= '0;
			pinOe       <= '0;
			pinPullup   <= '0;
			pinRxEnable <= '0;
		end else begin
			pinOut      <= next_pinOut;
			pinOe       <= next_pinOe;
			pinPullup   <= next_pinPullup;
			pinRxEnable <= next_pinRxEnable;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			perIn <= '1;
		end else begin
			perIn <= next_perIn;
		end
	end

endmodule : pxb_port_crossbar

// ===== verification/pxb_port_crossbar_monitor.sv
// Concurrent checks on the port crossbar block ports
`timescale 1ns/10ps
module pxb_port_crossbar_monitor (
	input wire logic                     mclk,
	input wire logic                     rstn,
	input wire logic [pxb_pkg::ADDR_W-1:0] regAddr,
	input wire logic [7:0]               regWrData,
	input wire logic                     regWr,
	input wire logic                     regRd,
	input wire logic [7:0]               regRdData,
	input wire logic [pxb_pkg::NPIN-1:0] pinOut,
	input wire logic [pxb_pkg::NPIN-1:0] pinOe,
	input wire logic [pxb_pkg::NPIN-1:0] pinPullup,
	input wire logic [pxb_pkg::NPIN-1:0] pinRxEnable,
	input wire logic [pxb_pkg::NSIG-1:0] perIn
);
	import pxb_pkg::*;
	// ------------------------------
	// Shadow of the settings the checks need
	// ------------------------------
	logic [NPIN-1:0] inMode;
	logic [7:0]      p4Lat;
	logic [7:0]      p4Om;
	logic            xbarOn;
	logic            wpud;
	logic [7:0]      oeExp4;
	logic [7:0]      puExp4;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			inMode <= RST_INMODE;
			p4Lat  <= 8'hff;
			p4Om   <= 8'h00;
			xbarOn <= 1'b0;
			wpud   <= 1'b0;
		end else if (regWr) begin
			if (regAddr[7:3] == REG_INMODE && regAddr[2:0] < 3'h5) begin
				inMode[8*regAddr[2:0] +: 8] <= regWrData;
			end
			if (regAddr == 8'h04) p4Lat <= regWrData;
			if (regAddr == 8'h14) p4Om <= regWrData;
			if (regAddr == 8'h21) {wpud, xbarOn} <= regWrData[7:6];
		end
	end
	assign oeExp4 = inMode[39:32] & (p4Om | ~p4Lat);
	assign puExp4 = inMode[39:32] & ~p4Om & p4Lat & {8{~wpud}};
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// ------------------------------
	// Assertions
	// ------------------------------
	chk_reset_digital: assert property ($rose(rstn) |=> pinRxEnable == RST_INMODE
		&& pinOe == '0 && pinPullup == RST_INMODE) else $error("pins not inputs after reset");
	chk_read_idle: assert property (!regRd |=> regRdData == 8'h00)
		else $error("read data outside its cycle");
	chk_rx_mode: assert property ($past(rstn) |-> pinRxEnable == $past(inMode))
		else $error("receiver enable differs from input mode");
	chk_analog_quiet: assert property (((pinOe | pinPullup) & ~pinRxEnable) == '0)
		else $error("analog pin drives or pulls up");
	chk_pull_zero: assert property ((pinPullup & pinOe & ~pinOut) == '0)
		else $error("pull-up on while driving low");
	chk_xbar_off: assert property ($past(rstn) && !$past(xbarOn) |-> pinOe[31:0] == '0)
		else $error("port 0 to 3 driver on without crossbar");
	chk_xbar_inputs: assert property (!xbarOn [*3] |-> perIn == '1)
		else $error("peripheral input routed without crossbar");
	chk_port4_gpio: assert property ($past(rstn) |-> pinOe[39:32] == $past(oeExp4))
		else $error("port 4 drive not plain gpio");
	chk_weak_pull: assert property ($past(rstn) |-> pinPullup[39:32] == $past(puExp4))
		else $error("port 4 pull-up wrong");
	cov_xbar_drive: cover property ($rose(pinOe[0]));
	cov_read_data: cover property (regRd ##1 regRdData != 8'h00);
	cov_pull_off: cover property ($fell(pinPullup[8]));
endmodule : pxb_port_crossbar_monitor

bind pxb_port_crossbar pxb_port_crossbar_monitor u_mon (.mclk(mclk), .rstn(rstn),
	.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData), .pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPullup),
	.pinRxEnable(pinRxEnable), .perIn(perIn));

// ===== verification/pxb_pad_model.sv
// Pad model: resolves each pin from chip drive, outside drive and pull-up
`timescale 1ns/10ps
module pxb_pad_model (
	input  wire logic                     mclk,
	input  wire logic [pxb_pkg::NPIN-1:0] pinOut,
	input  wire logic [pxb_pkg::NPIN-1:0] pinOe,
	input  wire logic [pxb_pkg::NPIN-1:0] pinPullup,
	input  wire logic [pxb_pkg::NPIN-1:0] extVal,
	input  wire logic [pxb_pkg::NPIN-1:0] extOe,
	output logic      [pxb_pkg::NPIN-1:0] pinIn
);
	import pxb_pkg::*;
	logic [NPIN-1:0] floatPat = '0;
	// A pin nobody holds toggles, so a stale level is never read as valid
	always_ff @(posedge mclk) begin
		floatPat <= ~floatPat;
	end
	always_comb begin
		pinIn = (pinOe & pinOut) | (~pinOe & extOe & extVal)
			| (~pinOe & ~extOe & (pinPullup | floatPat));
	end
endmodule : pxb_pad_model

// ===== verification/test_pxb_port_crossbar.sv
// Self-checking bench for the port crossbar block
`timescale 1ns/10ps
module test_pxb_port_crossbar;
	import pxb_pkg::*;
	logic              mclk;
	logic              rstn;
	logic              regWr;
	logic              regRd;
	logic [ADDR_W-1:0] regAddr;
	logic [7:0]        regWrData;
	logic [7:0]        regRdData;
	logic [NPIN-1:0]   pinIn, pinOut, pinOe, pinPullup, pinRxEnable, extVal, extOe;
	logic [NSIG-1:0]   perOut, perOe, perIn;
	int                failures;
	int                nTests;
	logic [7:0] rA[10] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h10, 8'h18, 8'h20, 8'h21, 8'h1c};

	pxb_port_crossbar DUT (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut),
		.pinOe(pinOe), .pinPullup(pinPullup), .pinRxEnable(pinRxEnable), .perOut(perOut),
		.perOe(perOe), .perIn(perIn));
	pxb_pad_model u_pads (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPullup),
		.extVal(extVal), .extOe(extOe), .pinIn(pinIn));

	// ------------------------------
	// Bus and compare tasks
	// ------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		nTests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWr     <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1;
		check(regRdData, e);
	endtask : rd
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wt
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", nTests, failures);
		if (failures == 0 && nTests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		repeat (3000) @(posedge mclk);
		failures++;
		test_done();
	end

	// ------------------------------
	// Tests
	// ------------------------------
	initial begin
		{rstn, regWr, regRd, regAddr, regWrData} = '0;
		{perOut, perOe, extVal, extOe} = '0;
		failures = 0;
		nTests = 0;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		for (int i = 0; i < 10; i++) rd(rA[i], (i < 5) ? 8'hff : 8'h00);
		$display("test reset values done");
		wr(8'h22, 8'hff);
		rd(8'h22, 8'h03);
		wr(8'h18, 8'h5a);
		rd(8'h18, 8'h5a);
		wr(8'h1c, 8'hff);
		rd(8'h1c, 8'h00);
		wr(8'h18, 8'h00);
		wr(8'h22, 8'h00);
		$display("test register access done");
		wr(8'h00, 8'ha5);
		wr(8'h10, 8'hff);
		wr(8'h04, 8'ha5);
		wr(8'h14, 8'hff);
		wt(2);
		check(pinOe[39:32], 8'hff);
		check(pinOut[39:32], 8'ha5);
		check(pinOe[7:0], 8'h00);
		wr(8'h21, 8'h40);
		wt(2);
		check(pinOe[7:0], 8'hff);
		check(pinOut[7:0], 8'ha5);
		$display("test crossbar gate done");
		wr(8'h0c, 8'h0f);
		wt(5);
		check(pinRxEnable[39:32], 8'h0f);
		check(pinOe[39:32], 8'h0f);
		rd(8'h04, 8'h05);
		check(pinPullup[39:32], 8'h00);
		wr(8'h01, 8'h0f);
		wt(2);
		check(pinOe[15:8], 8'hf0);
		check(pinPullup[15:8], 8'h0f);
		wr(8'h21, 8'hc0);
		// Outside drive on released open-drain pins of port 1
		extOe[15:8]  <= 8'h0f;
		extVal[15:8] <= 8'h05;
		wt(2);
		check(pinPullup[15:8], 8'h00);
		rd(8'h01, 8'h05);
		$display("test modes and pull-ups done");
		wr(8'h10, 8'h00);
		extOe[3] <= 1'b1;
		wr(8'h20, 8'h02);
		wt(5);
		check({7'h0, perIn[5]}, 8'h01);
		check({7'h0, pinOe[3]}, 8'h01);
		wr(8'h22, 8'h02);
		wt(5);
		check({7'h0, perIn[5]}, 8'h00);
		check({7'h0, pinOe[3]}, 8'h00);
		$display("test slave select done");
		wr(8'h22, 8'h00);
		wr(8'h10, 8'hff);
		perOut <= 23'h000001;
		perOe  <= 23'h000041;
		wr(8'h20, 8'h05);
		wt(2);
		check(pinOe[7:0], 8'hf7);
		check(pinOut[7:0], 8'ha3);
		@(posedge mclk);
		perOut <= 23'h000041;
		wt(2);
		check(pinOe[7:0], 8'hf3);
		wr(8'h18, 8'h01);
		wt(2);
		check(pinOe[7:0], 8'he7);
		check(pinOut[7:0], 8'ha7);
		// Second SMBus instance, then one capture/compare output driving low
		wr(8'h22, 8'h01);
		perOe <= 23'h008041;
		wt(2);
		check(pinOe[7:0], 8'h87);
		check(pinOut[7:0], 8'h87);
		wr(8'h21, 8'hc1);
		wt(2);
		check(pinOe[7:0], 8'h87);
		check(pinOut[7:0], 8'h07);
		$display("test routing done");
		test_done();
	end
endmodule : test_pxb_port_crossbar
